/* common/lcdo_pkg.sv */
// constants and carrier types for the lcd output interface block
package lcdo_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] DEV_CTRL_ADDR = 32'hb000_8004;
    localparam logic [31:0] CMD_CTRL_ADDR = 32'hb000_8080;
    localparam logic [31:0] CMD_WORD_ADDR = 32'hb000_8084;
    localparam logic [31:0] STATUS_ADDR = 32'hb000_8088;
    localparam logic [31:0] DEV_CTRL_RST = 32'h0000_00e0;
    localparam logic [31:0] DEV_CTRL_WMASK = 32'hffff_fffe;

    // ****************************************
    // device control fields
    // ****************************************
    localparam int CMD_LOW_BIT = 31;
    localparam int CMD_MAP_BIT = 30;
    localparam int WIDE_CMD_BIT = 29;
    localparam int POL_SHARE_BIT = 28;
    localparam int STROBE_BIT = 27;
    localparam int WORD_BIT = 26;
    localparam int DEPTH_LSB = 24;
    localparam int FIELD_ALTERNATING_DATA_BIT = 23;
    localparam int SYNC_FIELD_ALTERNATING_DATA_BIT = 22;
    localparam int VPOL_BIT = 21;
    localparam int HPOL_BIT = 20;
    localparam int LATCH_BIT = 19;
    localparam int ORDER_LSB = 17;
    localparam int RANGE_BIT = 16;
    localparam int DDA_LSB = 8;
    localparam int DEV_LSB = 5;
    localparam int SWAP_HI_BIT = 2;

    // command registers and status fields
    localparam int CMD_MODE_BIT = 0;
    localparam int PARAM_FLAG_BIT = 16;
    localparam int ST_PEND_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_BEAT_LSB = 2;
    localparam int ST_PCLK_BIT = 4;
    localparam int ST_MODE_BIT = 5;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [2:0] DEV_YUV422 = 3'h0;
    localparam logic [2:0] DEV_YUV444 = 3'h1;
    localparam logic [2:0] DEV_SYNC_A = 3'h4;
    localparam logic [2:0] DEV_SYNC_B = 3'h5;
    localparam logic [2:0] DEV_SYNC_HC = 3'h6;
    localparam logic [2:0] DEV_MPU = 3'h7;
    localparam logic [1:0] DEPTH_4K = 2'h0;
    localparam logic [1:0] DEPTH_64K = 2'h1;
    localparam logic [1:0] DEPTH_256K = 2'h2;
    localparam logic [1:0] DEPTH_16M = 2'h3;

    // studio range: out = ofs + in * span / 256
    localparam logic [7:0] STUDIO_OFS = 8'h10;
    localparam logic [7:0] LUMA_SPAN = 8'hdb;
    localparam logic [7:0] CHROMA_SPAN = 8'he0;

    localparam int HALF_W = 16;
    localparam logic [HALF_W-1:0] HALF_LINE_DEF = 16'h01ad;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lcdo_reg_req_type;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
        logic line_odd;
    } lcdo_pix_type;

    typedef struct packed {
        logic hs;
        logic vs;
        logic de;
        logic field_odd;
    } lcdo_sync_type;

    typedef struct packed {
        logic [31:0] ctrl;
        logic cmd_mode;
        logic [16:0] cmd_word;
        logic cmd_pend;
        logic [7:0] acc;
        logic pclk;
        logic [23:0] pix;
        logic [1:0] beat;
        logic busy;
        logic is_cmd;
        logic [16:0] cur_cmd;
        logic [17:0] bus;
        logic rs;
        logic wr_n;
        logic rd_n;
        logic e;
        logic rw;
        logic de;
        logic hs;
        logic vs;
        logic [HALF_W-1:0] hcnt;
        logic pix_ready;
        logic [31:0] rdata;
    } lcdo_state_type;

endpackage

/* hdl/lcdo_core.sv */
// lcd output interface: control register, pixel and command serialiser
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps

// How it works
// R1: command-low bit picks select levels for command versus data words.
// R2: command-mapping bit places zero padding low or high on 9/18-bit buses.
// R3: 16-bit commands only when wide-command and bus-word width are both set.
// R4: sync panels: shared bit makes display-enable active high (0) or low (1).
// R5: 262K MPU modules: shared bit picks 9/18-bit (0) or 8/16-bit (1) bus.
// R6: strobe-style bit picks 80-series (0) or 68-series (1) write strobes.
// R7: width bit 0 sends a pixel in two transfers, 1 in one transfer.
// R8: bus is 8/16 bits, or 8/9 and 16/18 bits in 262K mode.
// R9: 16M colours use an 8-bit bus, 3 beats, or 4 with swap bit 1.
// R10: colour-type field: 4096, 65536, 262144 or 16777216 colours.
// R11: data interlace bit sends only lines of the current field.
// R12: sync interlace bit shifts odd-field vertical sync by half a line.
// R13: sync polarity bits: 0 active low, 1 active high.
// R14: latch-edge bit launches data on falling (0) or rising (1) panel clock.
// R15: line-order field sets colour order on first and alternate lines.
// R16: range bit converts full-range YUV into studio range.
// R17: increment field drives the panel clock DDA for types 100 and 110.
// R18: control register is read-write and resets to 0x0000_00e0.
// R19: device-type field selects YUV, sync TFT or MPU-style output.
// R20: command mode sends command or parameter words instead of pixels.
// R21: accumulator adds increment each clock; each carry toggles panel clock.
// R22: bits 15 to 8 are stored; bit 0 reads zero and ignores writes.
module lcdo_core
    import lcdo_pkg::*;
#(
    parameter logic [HALF_W-1:0] HALF_LINE = HALF_LINE_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire lcdo_reg_req_type i_reg,
    input wire lcdo_pix_type i_pix,
    input wire lcdo_sync_type i_sync,
    output logic [31:0] o_rdata,
    output logic o_pix_ready,
    output logic [17:0] o_bus_data,
    output logic o_command_data_select_pin,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic o_e,
    output logic o_rw,
    output logic o_de,
    output logic o_hsync,
    output logic o_vsync,
    output logic o_panel_clk
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [7:0] to_studio(input logic [7:0] v,
                                             input logic [7:0] span);
        logic [15:0] p;
        p = 16'(v) * 16'(span);
        return p[15:8] + STUDIO_OFS;
    endfunction

    function automatic logic [23:0] reorder(input logic [23:0] rgb,
                                            input logic [1:0] sel,
                                            input logic odd);
        logic [1:0] idx;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        idx = sel ^ {odd, 1'b0};
        r = rgb[23:16];
        g = rgb[15:8];
        b = rgb[7:0];
        case (idx)
            2'h0: return {r, g, b};
            2'h1: return {b, g, r};
            2'h2: return {g, b, r};
            default: return {r, b, g};
        endcase
    endfunction

    function automatic logic nine_bus(input logic [31:0] c);
        return c[DEPTH_LSB +: 2] == DEPTH_256K && c[DEV_LSB + 2] &&
               !(c[DEV_LSB +: 3] == DEV_MPU && c[POL_SHARE_BIT]);
    endfunction

    function automatic logic byte_mode(input logic [31:0] c);
        return c[DEV_LSB +: 3] == DEV_YUV444 ||
               (c[DEV_LSB + 2] && c[DEPTH_LSB +: 2] == DEPTH_16M);
    endfunction

    function automatic logic [2:0] nbeats(input logic [31:0] c);
        if (c[DEV_LSB +: 3] == DEV_YUV444)
            return 3'd3;
        if (byte_mode(c))
            return c[SWAP_HI_BIT] ? 3'd4 : 3'd3;
        return c[WORD_BIT] ? 3'd1 : 3'd2;
    endfunction

    function automatic logic [17:0] pixel_beat(input logic [31:0] c,
                                               input logic [23:0] t,
                                               input logic [1:0] beat);
        logic [17:0] w;
        logic [15:0] w16;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] d;
        a = t[23:16];
        b = t[15:8];
        d = t[7:0];
        if (byte_mode(c)) begin
            case (beat)
                2'd0: return {10'h000, a};
                2'd1: return {10'h000, b};
                2'd2: return {10'h000, d};
                default: return 18'h00000;
            endcase
        end
        if (c[DEV_LSB +: 3] == DEV_YUV422) begin
            w = {2'b00, a, b};
        end else begin
            case (c[DEPTH_LSB +: 2])
                DEPTH_4K: w = {6'h00, a[7:4], b[7:4], d[7:4]};
                DEPTH_64K: w = {2'b00, a[7:3], b[7:2], d[7:3]};
                default: w = {a[7:2], b[7:2], d[7:2]};
            endcase
        end
        w16 = (c[DEPTH_LSB +: 2] == DEPTH_256K && c[DEV_LSB + 2]) ?
              w[17:2] : w[15:0];
        if (nine_bus(c)) begin
            if (c[WORD_BIT])
                return w;
            return (beat == 2'd0) ? {9'h000, w[17:9]} : {9'h000, w[8:0]};
        end
        if (c[WORD_BIT])
            return {2'b00, w16};
        return (beat == 2'd0) ? {10'h000, w16[15:8]} : {10'h000, w16[7:0]};
    endfunction

    function automatic logic [17:0] cmd_beat(input logic [31:0] c,
                                             input logic [15:0] cw);
        logic wide;
        wide = c[WIDE_CMD_BIT] && c[WORD_BIT];
        if (wide) begin
            if (nine_bus(c) && !c[CMD_MAP_BIT])
                return {cw[15:8], 1'b0, cw[7:0], 1'b0};
            return {2'b00, cw};
        end
        if (nine_bus(c) && !c[CMD_MAP_BIT])
            return {9'h000, cw[7:0], 1'b0};
        return {10'h000, cw[7:0]};
    endfunction

    // ****************************************
    // state
    // ****************************************
    lcdo_state_type r;
    lcdo_state_type n;
    logic launch;
    logic toggle;
    logic [8:0] sum;
    logic [2:0] dev;
    logic dda_dev;
    logic sync_dev;
    logic strobe_style_select;
    logic [23:0] trip;
    logic vs_want;

    always_comb begin
        n = r;
        dev = r.ctrl[DEV_LSB +: 3];
        dda_dev = dev == DEV_SYNC_A || dev == DEV_SYNC_HC;
        sync_dev = dev == DEV_SYNC_A || dev == DEV_SYNC_B ||
                   dev == DEV_SYNC_HC;
        strobe_style_select = dev == DEV_MPU && r.ctrl[STROBE_BIT];

        // register writes; bit 0 of control is masked off
        if (i_reg.wr) begin
            case (i_reg.addr)
                DEV_CTRL_ADDR:
                    n.ctrl = i_reg.wdata & DEV_CTRL_WMASK; // see R18 see R22
                CMD_CTRL_ADDR: n.cmd_mode = i_reg.wdata[CMD_MODE_BIT];
                CMD_WORD_ADDR: begin
                    if (!r.cmd_pend) begin
                        n.cmd_word = i_reg.wdata[16:0];
                        n.cmd_pend = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // register reads, answered in the next cycle
        n.rdata = 32'h0000_0000;
        if (i_reg.rd) begin
            case (i_reg.addr)
                DEV_CTRL_ADDR: n.rdata = r.ctrl;
                CMD_CTRL_ADDR: n.rdata = {31'h0000_0000, r.cmd_mode};
                CMD_WORD_ADDR: n.rdata = {15'h0000, r.cmd_word};
                STATUS_ADDR: begin
                    n.rdata[ST_PEND_BIT] = r.cmd_pend;
                    n.rdata[ST_BUSY_BIT] = r.busy;
                    n.rdata[ST_BEAT_LSB +: 2] = r.beat;
                    n.rdata[ST_PCLK_BIT] = r.pclk;
                    n.rdata[ST_MODE_BIT] = r.cmd_mode;
                end
                default: ;
            endcase
        end

        // panel clock: dda for types 100/110, half rate otherwise
        sum = {1'b0, r.acc} + {1'b0, r.ctrl[DDA_LSB +: 8]};
        if (dda_dev) begin
            n.acc = sum[7:0]; // see R21
            toggle = sum[8]; // see R17 see R21
        end else begin
            n.acc = 8'h00;
            toggle = 1'b1;
        end
        n.pclk = r.pclk ^ toggle;
        launch = toggle && (r.ctrl[LATCH_BIT] ? !r.pclk : r.pclk); // see R14

        // strobes are one cycle wide
        n.wr_n = 1'b1;
        n.rd_n = 1'b1;
        n.e = 1'b0;

        // send one beat at each launch edge
        if (r.busy && launch) begin
            if (r.is_cmd) begin
                n.bus = cmd_beat(r.ctrl, r.cur_cmd[15:0]); // see R2 see R3
                n.rs = r.ctrl[CMD_LOW_BIT] ^
                       ~r.cur_cmd[PARAM_FLAG_BIT]; // see R1
                n.busy = 1'b0;
            end else begin
                n.bus = pixel_beat(r.ctrl, r.pix,
                                   r.beat); // see R5 see R8 see R10
                n.rs = r.ctrl[CMD_LOW_BIT]; // see R1
                if ({1'b0, r.beat} ==
                    nbeats(r.ctrl) - 3'd1) begin // see R7 see R9
                    n.busy = 1'b0;
                    n.beat = 2'd0;
                end else begin
                    n.beat = r.beat + 2'd1;
                end
            end
            if (dev == DEV_MPU) begin
                if (strobe_style_select)
                    n.e = 1'b1; // see R6
                else
                    n.wr_n = 1'b0; // see R6
            end
        end

        // take a command or a pixel when idle
        trip = reorder(i_pix.data, r.ctrl[ORDER_LSB +: 2],
                       i_pix.line_odd); // see R15
        if (!r.ctrl[DEV_LSB + 2] && r.ctrl[RANGE_BIT]) begin
            trip = {to_studio(i_pix.data[23:16], LUMA_SPAN), // see R16
                    to_studio(i_pix.data[15:8], CHROMA_SPAN),
                    to_studio(i_pix.data[7:0], CHROMA_SPAN)};
        end else if (!r.ctrl[DEV_LSB + 2]) begin
            trip = i_pix.data; // see R19
        end
        if (!r.busy) begin
            if (r.cmd_mode && r.cmd_pend) begin
                n.cur_cmd = r.cmd_word; // see R20
                n.cmd_pend = 1'b0;
                n.is_cmd = 1'b1;
                n.busy = 1'b1;
                n.beat = 2'd0;
            end else if (i_pix.valid && r.pix_ready) begin
                if (!r.ctrl[FIELD_ALTERNATING_DATA_BIT] ||
                    i_pix.line_odd == i_sync.field_odd) begin // see R11
                    n.pix = trip;
                    n.is_cmd = 1'b0;
                    n.busy = 1'b1;
                    n.beat = 2'd0;
                end
            end
        end
        n.rw = !(strobe_style_select && (n.busy || n.e)); // see R6
        n.pix_ready = !n.busy && !n.cmd_mode; // see R20

        // sync outputs and display enable
        n.hs = i_sync.hs ^ ~r.ctrl[HPOL_BIT]; // see R13
        n.de = sync_dev && (i_sync.de ^ r.ctrl[POL_SHARE_BIT]); // see R4
        vs_want = i_sync.vs ^ ~r.ctrl[VPOL_BIT]; // see R13
        if (!r.ctrl[SYNC_FIELD_ALTERNATING_DATA_BIT] || !i_sync.field_odd) begin
            n.vs = vs_want;
            n.hcnt = '0;
        end else if (vs_want != r.vs) begin
            if (r.hcnt == HALF_LINE - 16'd1) begin // see R12
                n.vs = vs_want;
                n.hcnt = '0;
            end else begin
                n.hcnt = r.hcnt + 16'd1;
            end
        end else begin
            n.hcnt = '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            r <= '0;
            r.ctrl <= DEV_CTRL_RST; // see R18
            r.wr_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.rw <= 1'b1;
            r.hs <= 1'b1;
            r.vs <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.rdata;
    assign o_pix_ready = r.pix_ready;
    assign o_bus_data = r.bus;
    assign o_command_data_select_pin = r.rs;
    assign o_wr_n = r.wr_n;
    assign o_rd_n = r.rd_n;
    assign o_e = r.e;
    assign o_rw = r.rw;
    assign o_de = r.de;
    assign o_hsync = r.hs;
    assign o_vsync = r.vs;
    assign o_panel_clk = r.pclk;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_strobe_pulse;
        !o_wr_n ##1 o_wr_n;
    endsequence

    a_rs_level: assert property ( // see R1
        r.busy && r.is_cmd && launch |=> o_command_data_select_pin ==
        ($past(r.ctrl[CMD_LOW_BIT]) ^ ~$past(r.cur_cmd[PARAM_FLAG_BIT])))
        else $error("register select level wrong for command word");

    a_cmd_map_low: assert property ( // see R2
        r.busy && r.is_cmd && launch && nine_bus(r.ctrl) &&
        !r.ctrl[CMD_MAP_BIT] && !r.ctrl[WIDE_CMD_BIT]
        |=> o_bus_data[8:0] == {$past(r.cur_cmd[7:0]), 1'b0})
        else $error("9-bit command mapping wrong");

    a_wide_cmd_gate: assert property ( // see R3
        r.busy && r.is_cmd && launch && !r.ctrl[WORD_BIT]
        |=> o_bus_data[17:9] == 9'h000)
        else $error("16-bit command sent on half-word bus");

    a_de_polarity: assert property ( // see R4
        r.ctrl[DEV_LSB + 2] && r.ctrl[DEV_LSB +: 3] != DEV_MPU
        |=> o_de == ($past(i_sync.de) ^ $past(r.ctrl[POL_SHARE_BIT])))
        else $error("display enable polarity wrong");

    a_mpu_strobe: assert property ( // see R6
        r.busy && launch && r.ctrl[DEV_LSB +: 3] == DEV_MPU &&
        !r.ctrl[STROBE_BIT] |=> s_strobe_pulse)
        else $error("80-series write strobe not a one-cycle pulse");

    a_pixel_beats: assert property ( // see R7 see R9
        r.busy && !r.is_cmd && launch &&
        {1'b0, r.beat} == nbeats(r.ctrl) - 3'd1 |=> !r.busy ##1 r.beat == 2'd0)
        else $error("pixel did not end after its beat count");

    a_hs_polarity: assert property ( // see R13
        ##1 1'b1 |-> o_hsync == ($past(i_sync.hs) ^ ~$past(r.ctrl[HPOL_BIT])))
        else $error("horizontal sync polarity wrong");

    a_dda_off: assert property ( // see R17
        (r.ctrl[DEV_LSB +: 3] == DEV_SYNC_A &&
         r.ctrl[DDA_LSB +: 8] == 8'h00) [*2] |-> $stable(o_panel_clk))
        else $error("panel clock runs with zero increment");

    a_ctrl_reset: assert property ( // see R18
        $past(i_rst) |-> r.ctrl == DEV_CTRL_RST)
        else $error("control register reset value wrong");

    a_reserved_bit: assert property ( // see R22
        i_reg.rd && i_reg.addr == DEV_CTRL_ADDR |=> o_rdata[0] == 1'b0)
        else $error("reserved bit reads non-zero");

endmodule

/* bench/lcdo_panel_model.sv */
// panel-side model: captures every bus transfer at its write strobe
`timescale 1ns/100ps
module lcdo_panel_model
    import lcdo_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_clr,
    input wire logic [17:0] i_bus,
    input wire logic i_rs,
    input wire logic i_wr_n,
    input wire logic i_e,
    input wire logic i_rw,
    output logic [3:0][17:0] o_beats,
    output logic o_rs,
    output int o_n,
    output int o_n_e
);
    // ****************************************
    // transfer capture
    // ****************************************
    // 80-style latches on a low write strobe, 68-style on enable with write
    always_ff @(posedge i_core_clk) begin
        if (i_clr) begin
            o_n <= 0;
            o_n_e <= 0;
            o_beats <= '0;
        end else if (!i_wr_n || (i_e && !i_rw)) begin
            o_beats[o_n[1:0]] <= i_bus;
            o_rs <= i_rs;
            o_n <= o_n + 1;
            if (i_e) begin
                o_n_e <= o_n_e + 1;
            end
        end
    end
endmodule

/* bench/tb_lcd_output_interface_config.sv */
// self-checking bench for the lcd output interface core
`timescale 1ns/100ps
module tb_lcd_output_interface_config
    import lcdo_pkg::*;
();
    localparam logic [31:0] B_LOW = 32'h8000_0000;
    localparam logic [31:0] B_MAP = 32'h4000_0000;
    localparam logic [31:0] B_WIDE = 32'h2000_0000;
    localparam logic [31:0] B_SHR = 32'h1000_0000;
    localparam logic [31:0] B_STB = 32'h0800_0000;
    localparam logic [31:0] B_WORD = 32'h0400_0000;
    localparam logic [31:0] D_64K = 32'h0100_0000;
    localparam logic [31:0] D_256K = 32'h0200_0000;
    localparam logic [31:0] D_16M = 32'h0300_0000;
    localparam logic [31:0] B_FIELD_ALTERNATING_DATA = 32'h0080_0000;
    localparam logic [31:0] B_VPOL = 32'h0020_0000;
    localparam logic [31:0] B_HPOL = 32'h0010_0000;
    localparam logic [31:0] B_SWAP = 32'h0000_0004;
    localparam logic [31:0] T_MPU = 32'h0000_00e0;
    localparam logic [31:0] T_SYNC = 32'h0000_0080;
    localparam logic [31:0] T_HC = 32'h0000_00c0;
    localparam logic [31:0] BASE = T_MPU | D_256K;
    // command cases: control, word, expected bus, expected select level
    localparam logic [31:0] CC [7] = '{BASE | B_WORD | B_WIDE,
        BASE | B_WORD | B_WIDE | B_MAP | B_LOW, BASE,
        BASE | B_MAP | B_LOW, T_MPU | D_64K | B_WORD | B_WIDE | B_STB,
        BASE | B_WORD | B_WIDE | B_SHR, BASE | B_WIDE};
    localparam logic [16:0] CW [7] = '{17'h012ab, 17'h012ab, 17'h100ab,
        17'h100ab, 17'h012ab, 17'h012ab, 17'h012ab};
    localparam logic [17:0] CB [7] = '{18'h04956, 18'h012ab, 18'h00156,
        18'h000ab, 18'h012ab, 18'h012ab, 18'h00156};
    localparam logic CR [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    // pixel cases: control, odd line, expected beat count
    localparam logic [31:0] PC [6] = '{T_MPU | D_64K | B_WORD, T_MPU | D_64K,
        T_MPU | D_16M, T_MPU | D_16M | B_SWAP, T_MPU | D_16M | B_FIELD_ALTERNATING_DATA,
        T_MPU | D_16M};
    localparam logic PO [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam int PN [6] = '{1, 2, 3, 4, 0, 3};
    // expected bytes, first beat in the top byte; zero where not checked
    localparam logic [3:0][7:0] PB [6] = '{32'h0, 32'h0, 32'h1234_5600,
        32'h1234_5600, 32'h0, 32'h3456_1200};

    logic core_clk;
    logic rst;
    logic clr;
    lcdo_reg_req_type reg_req;
    lcdo_pix_type pix;
    lcdo_sync_type sync_in;
    logic [31:0] rdata;
    logic [31:0] rd_val;
    logic pix_ready;
    logic [17:0] bus;
    logic rs, wr_n, rd_n, e, rw, de, hs, vs, pclk;
    logic [3:0][17:0] beats;
    logic beat_rs;
    int n_beat;
    int n_e;
    int n_fail;
    int comparisons;

    lcdo_core #(.HALF_LINE(16'h0004)) i_dut (.i_core_clk(core_clk),
        .i_rst(rst), .i_reg(reg_req), .i_pix(pix), .i_sync(sync_in),
        .o_rdata(rdata), .o_pix_ready(pix_ready), .o_bus_data(bus),
        .o_command_data_select_pin(rs), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .o_e(e), .o_rw(rw), .o_de(de), .o_hsync(hs), .o_vsync(vs),
        .o_panel_clk(pclk));
    lcdo_panel_model i_panel (.i_core_clk(core_clk), .i_clr(clr),
        .i_bus(bus), .i_rs(rs), .i_wr_n(wr_n), .i_e(e), .i_rw(rw),
        .o_beats(beats), .o_rs(beat_rs), .o_n(n_beat), .o_n_e(n_e));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cnt(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req <= '0;
        #1 d = rdata;
    endtask
    task automatic clear();
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask
    task automatic toggles(input logic [31:0] c, input int exp);
        logic prev;
        int n;
        wr(DEV_CTRL_ADDR, c);
        cyc(8);
        #1 prev = pclk;
        n = 0;
        repeat (64) begin
            @(posedge core_clk);
            #1 if (pclk !== prev) n++;
            prev = pclk;
        end
        chk_cnt("panel clock toggles", exp, n);
    endtask
    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        $display("Error watchdog expected done seen timeout");
        end_sim();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        int k;
        rst = 1'b1;
        clr = 1'b0;
        reg_req = '0;
        pix = '0;
        sync_in = '0;
        n_fail = 0;
        comparisons = 0;
        cyc(16);
        rst <= 1'b0;
        rd(DEV_CTRL_ADDR, rd_val);
        chk_word("control reset", DEV_CTRL_RST, rd_val);
        rd(32'hb000_8000, rd_val);
        chk_word("unmapped read", 32'h0, rd_val);
        wr(32'hb000_8000, 32'hffff_ffff);
        wr(DEV_CTRL_ADDR, 32'hffff_ffff);
        rd(DEV_CTRL_ADDR, rd_val);
        chk_word("control all ones", 32'hffff_fffe, rd_val);
        rd(32'hb000_8000, rd_val);
        chk_word("unmapped after write", 32'h0, rd_val);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            wr(DEV_CTRL_ADDR, CC[i]);
            wr(CMD_CTRL_ADDR, 32'h1);
            clear();
            wr(CMD_WORD_ADDR, {15'h0, CW[i]});
            cyc(30);
            chk_cnt("command beats", 1, n_beat);
            chk_word("command bus", {14'h0, CB[i]},
                     {14'h0, beats[0]});
            chk_word("command select", {31'h0, CR[i]},
                     {31'h0, beat_rs});
            chk_cnt("68 strobes", (i == 4) ? 1 : 0, n_e);
            chk_word("read strobe", 32'h1, {31'h0, rd_n});
            wr(CMD_CTRL_ADDR, 32'h0);
        end
        $display("test commands done");
        for (int i = 0; i < 6; i++) begin
            wr(DEV_CTRL_ADDR, PC[i]);
            clear();
            pix <= '{valid: 1'b1, data: 24'h123456, line_odd: PO[i]};
            k = 0;
            @(posedge core_clk);
            while (pix_ready !== 1'b1 && k < 200) begin
                @(posedge core_clk);
                k++;
            end
            pix <= '0;
            cyc(60);
            chk_cnt("pixel beats", PN[i], n_beat);
            if (PB[i] != 32'h0) begin
                for (int b = 0; b < PN[i]; b++) begin
                    chk_word("pixel byte", {24'h0, PB[i][3-b]},
                             {14'h0, beats[b]});
                end
            end
        end
        $display("test pixels done");
        for (int i = 0; i < 2; i++) begin
            wr(DEV_CTRL_ADDR,
               i == 0 ? T_SYNC | B_HPOL : T_SYNC | B_VPOL | B_SHR);
            for (int lv = 0; lv < 2; lv++) begin
                sync_in <= '{hs: lv[0], vs: lv[0], de: lv[0], field_odd: 1'b0};
                cyc(4);
                chk_word("sync outputs", {29'h0, lv[0] ^ (i != 0),
                    lv[0] ^ (i == 0), lv[0] ^ (i != 0)},
                    {29'h0, hs, vs, de});
            end
        end
        sync_in <= '0;
        $display("test syncs done");
        toggles(T_SYNC | 32'h0000_8000, 32);
        toggles(T_SYNC, 0);
        toggles(T_HC | 32'h0000_4000, 16);
        toggles(T_MPU, 64);
        $display("test panel clock done");
        end_sim();
    end
endmodule
